// ---- clock_synth_pkg.sv ----
// Package for the clock synthesizer serial control port and its output gating.
// Assumes a 20 MHz system clock and a separate free-running synthesized clock.
package clock_synth_pkg;

    // Slave address, upper seven bits of the address byte 8'hD2
    localparam logic [6:0] DEV_ADDR = 7'h69;

    // Command byte layout
    localparam int CMD_BYTE_BIT = 7;
    localparam logic [6:0] BLOCK_INDEX = 7'h00;

    // Configuration byte file
    localparam int NUM_BYTES = 8;
    localparam int BYTE_SEL_W = 3;
    localparam logic [6:0] NUM_BYTES_IDX = 7'h08;
    localparam logic [7:0] BLOCK_COUNT = 8'h08;
    localparam logic [NUM_BYTES-1:0][7:0] CFG_RESET = 64'hFFFF_FFFF_FFFF_FF00;

    // Gated clock outputs, enabled by the bits of two consecutive bytes
    localparam int NUM_OUTS = 16;
    localparam int OUT_EN_BYTE_LO = 1;
    localparam int OUT_EN_BYTE_HI = 2;

    // Bit counting within a byte
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // Power-up settling of the oscillators
    localparam int CLK_PERIOD_NS = 50;
    localparam int STABLE_TIME_NS = 500000;
    localparam int STABLE_CYCLES_DEF = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABLE_CNT_W = 24;

    // The two serial lines, carried together
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_s;

    localparam lines_s LINES_IDLE = 2'h3;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_CMD       = 4'h3,
        ST_CMD_ACK   = 4'h4,
        ST_COUNT     = 4'h5,
        ST_COUNT_ACK = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h8,
        ST_TX        = 4'h9,
        ST_TX_ACK    = 4'hA,
        ST_IGNORE    = 4'hB
    } slave_state_e;

endpackage : clock_synth_pkg

// ---- line_sync.sv ----
// Three-stage synchroniser for the two serial lines.
// Assumes the lines are idle high and change far slower than clk.
`timescale 1ns/1ps
module line_sync (
    input wire logic clk,
    input wire logic rst,
    input wire clock_synth_pkg::lines_s raw,
    output clock_synth_pkg::lines_s clean
);
    import clock_synth_pkg::*;

    lines_s s1_q, s1_d;
    lines_s s2_q, s2_d;
    lines_s s3_q, s3_d;
    lines_s clean_q, clean_d;

    // A change is accepted only once the second and third stages agree
    always_comb
    begin
        s1_d = raw;
        s2_d = s1_q;
        s3_d = s2_q;
        clean_d = clean_q;
        if (s2_q.scl == s3_q.scl)
            clean_d.scl = s3_q.scl;
        if (s2_q.sda == s3_q.sda)
            clean_d.sda = s3_q.sda;
    end

    // Stage registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= LINES_IDLE;
            s2_q <= LINES_IDLE;
            s3_q <= LINES_IDLE;
            clean_q <= LINES_IDLE;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign clean = clean_q;

endmodule : line_sync

// ---- clock_gate_bank.sv ----
// Glitch-free gating of the synthesized clock onto each output.
// Assumes clk_src runs free; enables arrive as levels from the clk domain.
`timescale 1ns/1ps
module clock_gate_bank (
    input wire logic clk_src,
    input wire logic rst,
    input wire logic [clock_synth_pkg::NUM_OUTS-1:0] enable,
    output logic [clock_synth_pkg::NUM_OUTS-1:0] clk_out
);
    import clock_synth_pkg::*;

    logic [NUM_OUTS-1:0] en1_q, en1_d;
    logic [NUM_OUTS-1:0] en2_q, en2_d;
    logic [NUM_OUTS-1:0] en3_q, en3_d;
    logic [NUM_OUTS-1:0] gate_q, gate_d;

    // Three-flop crossing; a gate bit moves only once stages two and three agree
    always_comb
    begin
        en1_d = enable;
        en2_d = en1_q;
        en3_d = en2_q;
        gate_d = (en2_q & en3_q) | (gate_q & (en2_q | en3_q));
    end

    // Crossing flops on the rising edge
    always_ff @(posedge clk_src or posedge rst)
    begin
        if (rst)
        begin
            en1_q <= '0;
            en2_q <= '0;
            en3_q <= '0;
        end
        else
        begin
            en1_q <= en1_d;
            en2_q <= en2_d;
            en3_q <= en3_d;
        end
    end

    // Gate moves only while the source is low, so no high phase is cut
    always_ff @(negedge clk_src or posedge rst)
    begin
        if (rst)
            gate_q <= '0;
        else
            gate_q <= gate_d;
    end

    // A stopped output sits low
    for (genvar g = 0; g < NUM_OUTS; g++)
    begin : g_out
        assign clk_out[g] = clk_src & gate_q[g];
    end

endmodule : clock_gate_bank

// ---- clock_synth_smbus_slave.sv ----
// Serial control port of the clock synthesizer and its output enables.
// Assumes the host drives SCL; the pads resolve the open-drain data line.
//
// How it works
// - Each clock output is enabled or stopped by its own configuration bit.
// - A stopped clock output is held low.
// - Start and stop of an output never shorten a high phase.
// - Outputs stay stopped until the oscillators have settled, about half a millisecond.
// - Configuration bytes take their defaults at reset; the port is optional.
// - Byte write, byte read, block write and block read are accepted.
// - Block bytes go in ascending index from byte zero, MSB first.
// - A block may end after any whole byte; completed bytes are kept.
// - Responds only at address byte D2h, write or read in bit zero.
// - Command bit 7 low selects block, high selects single indexed byte.
// - Command bits 6 to 0 index the single byte; zero for block.
// - Block write: address, command, count, then data bytes, all acknowledged.
// - Block read: after repeated start and read address, count byte is returned first.
// - Block read sends data bytes until the host answers not-acknowledge.
// - Byte write: address, indexed command, one data byte, acknowledged, stop.
// - Byte read: repeated start, read address, one byte, host not-acknowledge, stop.
// - Address, command, count and each written data byte are acknowledged.
// - Data pin is only ever pulled low, during acknowledge or transmit.
// - Serial clock is only an input; the host makes all link clocking.
`timescale 1ns/1ps
module clock_synth_smbus_slave #(
    parameter int STABLE_CYCLES = clock_synth_pkg::STABLE_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_src,
    input wire logic scl_i,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    output logic [clock_synth_pkg::NUM_OUTS-1:0] clk_out,
    output logic clocks_ready
);
    import clock_synth_pkg::*;

    // Data byte at an index, zero beyond the byte file
    function automatic logic [7:0] read_byte(
        input logic [NUM_BYTES-1:0][7:0] file,
        input logic [6:0] idx
    );
        logic [7:0] value;
        value = 8'h00;
        if (idx < NUM_BYTES_IDX)
            value = file[idx[BYTE_SEL_W-1:0]];
        return value;
    endfunction : read_byte

    lines_s raw_lines;
    lines_s lines;
    lines_s prev_q, prev_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    slave_state_e state_q, state_d;
    logic [BIT_CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] cmd_q, cmd_d;
    logic [6:0] idx_q, idx_d;
    logic rw_q, rw_d;
    logic oe_q, oe_d;
    logic host_ack_q, host_ack_d;
    logic [NUM_BYTES-1:0][7:0] cfg_q, cfg_d;

    logic [STABLE_CNT_W-1:0] stable_q, stable_d;
    logic ready_q, ready_d;
    logic [NUM_OUTS-1:0] en_q, en_d;

    // Both serial pins are plain inputs sampled here
    assign raw_lines = '{scl: scl_i, sda: serial_data_pin_i};

    line_sync u_sync (
        .clk(clk),
        .rst(rst),
        .raw(raw_lines),
        .clean(lines)
    );

    // Edges of SCL and the start and stop conditions
    assign scl_rise = lines.scl & ~prev_q.scl;
    assign scl_fall = ~lines.scl & prev_q.scl;
    assign start_seen = prev_q.scl & lines.scl & prev_q.sda & ~lines.sda;
    assign stop_seen = prev_q.scl & lines.scl & ~prev_q.sda & lines.sda;

    // Serial slave: next state, shifter, index and byte file
    always_comb
    begin
        prev_d = lines;
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        idx_d = idx_q;
        rw_d = rw_q;
        oe_d = oe_q;
        host_ack_d = host_ack_q;
        cfg_d = cfg_q;
        if (stop_seen)
        begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            cnt_d = '0;
        end
        else if (start_seen)
        begin
            state_d = ST_ADDR;
            oe_d = 1'b0;
            cnt_d = '0;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], lines.sda};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == BYTE_BITS)
                    begin
                        cnt_d = '0;
                        oe_d = 1'b1;
                        case (state_q)
                            ST_ADDR:
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    rw_d = shift_q[0];
                                    state_d = ST_ADDR_ACK;
                                end
                                else
                                begin
                                    oe_d = 1'b0;
                                    state_d = ST_IGNORE;
                                end
                            end
                            ST_CMD:
                            begin
                                cmd_d = shift_q;
                                // Single access takes its index, block starts at zero
                                if (shift_q[CMD_BYTE_BIT])
                                    idx_d = shift_q[6:0];
                                else
                                    idx_d = BLOCK_INDEX;
                                state_d = ST_CMD_ACK;
                            end
                            ST_COUNT:
                                state_d = ST_COUNT_ACK;
                            default:
                            begin
                                // Whole data byte: commit and step to the next index
                                if (idx_q < NUM_BYTES_IDX)
                                    cfg_d[idx_q[BYTE_SEL_W-1:0]] = shift_q;
                                idx_d = idx_q + 7'h01;
                                state_d = ST_WDATA_ACK;
                            end
                        endcase
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw_q)
                        begin
                            // Read: block opens with the count, single with the byte
                            if (cmd_q[CMD_BYTE_BIT])
                            begin
                                shift_d = read_byte(cfg_q, idx_q);
                                idx_d = idx_q + 7'h01;
                            end
                            else
                                shift_d = BLOCK_COUNT;
                            oe_d = ~shift_d[7];
                            cnt_d = '0;
                            state_d = ST_TX;
                        end
                        else
                        begin
                            oe_d = 1'b0;
                            state_d = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        state_d = cmd_q[CMD_BYTE_BIT] ? ST_WDATA : ST_COUNT;
                    end
                end
                ST_COUNT_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        state_d = ST_WDATA;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_q == LAST_TX_BIT)
                        begin
                            oe_d = 1'b0; // Release for the host's answer
                            cnt_d = '0;
                            state_d = ST_TX_ACK;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d = ~shift_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        host_ack_d = ~lines.sda;
                    else if (scl_fall)
                    begin
                        if (host_ack_q)
                        begin
                            shift_d = read_byte(cfg_q, idx_q);
                            idx_d = idx_q + 7'h01;
                            oe_d = ~shift_d[7];
                            state_d = ST_TX;
                        end
                        else
                            state_d = ST_IGNORE;
                    end
                end
                default:
                    oe_d = 1'b0; // Idle or ignoring: line released
            endcase
        end
    end

    // Serial slave registers; the byte file starts from its defaults
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_q <= LINES_IDLE;
            state_q <= ST_IDLE;
            cnt_q <= '0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            idx_q <= 7'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            host_ack_q <= 1'b0;
            cfg_q <= CFG_RESET;
        end
        else
        begin
            prev_q <= prev_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            idx_q <= idx_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            host_ack_q <= host_ack_d;
            cfg_q <= cfg_d;
        end
    end

    // Settling wait, then the enable bits drive the gates
    always_comb
    begin
        stable_d = stable_q;
        ready_d = ready_q;
        if (!ready_q)
        begin
            if (stable_q == STABLE_CNT_W'(STABLE_CYCLES - 1))
                ready_d = 1'b1;
            else
                stable_d = stable_q + 24'h000001;
        end
        en_d = '0;
        if (ready_q)
            en_d = {cfg_q[OUT_EN_BYTE_HI], cfg_q[OUT_EN_BYTE_LO]};
    end

    // Settling counter and registered enables
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stable_q <= '0;
            ready_q <= 1'b0;
            en_q <= '0;
        end
        else
        begin
            stable_q <= stable_d;
            ready_q <= ready_d;
            en_q <= en_d;
        end
    end

    clock_gate_bank u_gates (
        .clk_src(clk_src),
        .rst(rst),
        .enable(en_q),
        .clk_out(clk_out)
    );

    // Open-drain data pin: only ever pulled low
    assign serial_data_pin_o = 1'b0;
    assign serial_data_pin_oe = oe_q;
    assign clocks_ready = ready_q;

endmodule : clock_synth_smbus_slave

// ---- clock_synth_smbus_slave_checker.sv ----
// Concurrent checks on the serial control port and the gated clock outputs.
// Assumes it is bound to the port top; all checks are sampled on clk.
`timescale 1ns/1ps
module clock_synth_smbus_slave_checker #(
    parameter int STABLE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_src,
    input wire logic scl_i,
    input wire logic serial_data_pin_i,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe,
    input wire logic [clock_synth_pkg::NUM_OUTS-1:0] clk_out,
    input wire logic clocks_ready
);
    import clock_synth_pkg::*;
    int cnt_q;
    int cnt_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since reset release, saturating
    always_comb cnt_d = (cnt_q < 1000) ? cnt_q + 1 : cnt_q;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            cnt_q <= 0;
        else
            cnt_q <= cnt_d;
    // Start and stop conditions made by the host
    sequence start_seq;
        scl_i && $past(scl_i) && $fell(serial_data_pin_i);
    endsequence
    sequence stop_seq;
        scl_i && $past(scl_i) && $rose(serial_data_pin_i);
    endsequence
    a_data_never_high: assert property (serial_data_pin_o == 1'b0)
        else $error("data pin output driven high");
    a_dark_before_ready: assert property (!clocks_ready |-> clk_out == '0)
        else $error("output ran before settling");
    a_ready_holds: assert property (clocks_ready |=> clocks_ready)
        else $error("ready dropped");
    a_ready_on_time: assert property ($rose(clocks_ready) |->
        cnt_q >= STABLE_CYCLES - 1 && cnt_q <= STABLE_CYCLES + 1)
        else $error("ready rose at wrong time");
    a_ready_not_late: assert property (cnt_q == STABLE_CYCLES + 2 |-> clocks_ready)
        else $error("ready late");
    a_oe_quiet_high: assert property (scl_i && $past(scl_i) |-> $stable(serial_data_pin_oe))
        else $error("data drive changed while clock high");
    a_ack_stands: assert property ($rose(serial_data_pin_oe) |=> serial_data_pin_oe [*8])
        else $error("drive pulse too short");
    a_start_releases: assert property (start_seq |-> ##1 !serial_data_pin_oe [*8])
        else $error("drive after start");
    a_stop_releases: assert property (stop_seq |-> !serial_data_pin_oe [*8])
        else $error("drive after stop");
    a_out_within_src: assert property ((clk_out & ~{NUM_OUTS{clk_src}}) == '0)
        else $error("output high while source low");
endmodule : clock_synth_smbus_slave_checker

bind clock_synth_smbus_slave clock_synth_smbus_slave_checker #(
    .STABLE_CYCLES(STABLE_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .clk_src(clk_src), .scl_i(scl_i),
    .serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe(serial_data_pin_oe), .clk_out(clk_out),
    .clocks_ready(clocks_ready)
);

// ---- smbus_host_model.sv ----
// Behavioural system host for the two-wire control port.
// Assumes a pull-up on the data wire; changes lines just after clk rises.
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic clk,
    input wire logic [7:0] half,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Wait for clk edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Start or repeated start, data pulled low while the clock line is high
    task automatic start();
        tick(2);
        sda_oe <= 1'b0;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_oe <= 1'b1;
        tick(half);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        tick(2);
        sda_oe <= 1'b1;
        tick(half);
        scl <= 1'b1;
        tick(half);
        sda_oe <= 1'b0;
        tick(half);
    endtask : stop
    // One bit cell, data set while clock low, sampled late in the high phase
    task automatic bit_cell(input logic b, output logic r);
        tick(2);
        sda_oe <= !b;
        tick(half);
        scl <= 1'b1;
        tick(half);
        r = sda;
        scl <= 1'b0;
    endtask : bit_cell
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_cell(d[i], r);
        bit_cell(1'b1, r);
        ack = !r;
    endtask : send
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cell(1'b1, r);
            d[i] = r;
        end
        bit_cell(!more, r);
    endtask : recv
endmodule : smbus_host_model

// ---- clock_synth_smbus_slave_tb_top.sv ----
// Self-checking bench for the clock synthesizer serial control port.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module clock_synth_smbus_slave_tb_top;
    import clock_synth_pkg::*;
    logic clk = 1'b0;
    logic clk_src = 1'b0;
    logic rst = 1'b1;
    logic [7:0] half = 8'h0A;
    logic scl;
    logic host_oe;
    logic sda_o;
    logic sda_oe;
    wire logic sda_w;
    logic [NUM_OUTS-1:0] clk_out;
    logic [NUM_OUTS-1:0] prev_out = '0;
    logic ready;
    logic [7:0] mdl [NUM_BYTES];
    logic [31:0] seed = 32'hAB58;
    realtime t_rise [NUM_OUTS];
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    // Clocks and the pulled-up data wire
    always #25 clk = ~clk;
    initial
    begin
        #1.3;
        forever #3 clk_src = ~clk_src;
    end
    assign sda_w = !(host_oe || (sda_oe && !sda_o));
    clock_synth_smbus_slave #(.STABLE_CYCLES(20)) DUT (
        .clk(clk), .rst(rst), .clk_src(clk_src), .scl_i(scl),
        .serial_data_pin_i(sda_w), .serial_data_pin_o(sda_o),
        .serial_data_pin_oe(sda_oe), .clk_out(clk_out), .clocks_ready(ready));
    smbus_host_model u_host (.clk(clk), .half(half), .sda(sda_w), .scl(scl), .sda_oe(host_oe));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // Cut a hung run short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            end_sim();
        end
    end
    // Every high phase of a gated output lasts a full source half period
    always @(clk_out)
    begin
        for (int i = 0; i < NUM_OUTS; i++)
            if (clk_out[i] && !prev_out[i])
                t_rise[i] = $realtime;
            else if (!clk_out[i] && prev_out[i] && !rst)
                chk("high_width", 1, 16'(($realtime - t_rise[i]) > 2.9));
        prev_out = clk_out;
    end
    task automatic wr(input logic [7:0] d);
        logic a;
        u_host.send(d, a);
        chk("ack", 1, 16'(a));
    endtask : wr
    task automatic rd_open(input logic [7:0] cmd);
        u_host.start();
        wr(8'hD2);
        wr(cmd);
        u_host.start();
        wr(8'hD3);
    endtask : rd_open
    task automatic rd_get(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        u_host.recv(more, d);
        chk("read_byte", 16'(exp), 16'(d));
    endtask : rd_get
    // Outputs that ran in a window must match the enable bytes
    task automatic outs_check();
        logic [15:0] seen;
        seen = '0;
        repeat (4) @(posedge clk);
        repeat (30)
        begin
            @(posedge clk_src);
            #1;
            seen |= clk_out;
        end
        chk("outputs_running", {mdl[2], mdl[1]}, seen);
    endtask : outs_check
    // Main sequence
    initial
    begin
        logic [7:0] v;
        logic a;
        int n;
        for (int i = 0; i < NUM_BYTES; i++)
            mdl[i] = CFG_RESET[i];
        repeat (16) @(posedge clk);
        chk("reset_outputs", 0, clk_out);
        chk("reset_flags", 0, {sda_oe, ready});
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        chk("ready", 1, 16'(ready));
        outs_check();
        for (int i = 0; i < NUM_BYTES; i++)
        begin
            rd_open({1'b1, 7'(i)});
            rd_get(1'b0, mdl[i]);
            u_host.stop();
        end
        for (int k = 0; k < 4; k++)
        begin
            v = rnd();
            n = 1 + k % 2;
            u_host.start();
            wr(8'hD2);
            wr({1'b1, 7'(n)});
            wr(v);
            u_host.stop();
            mdl[n] = v;
            outs_check();
        end
        n = 1 + int'(rnd() % 8);
        u_host.start();
        wr(8'hD2);
        wr(8'h00);
        wr(8'(n));
        for (int i = 0; i < n; i++)
        begin
            v = rnd();
            wr(v);
            mdl[i] = v;
        end
        u_host.stop();
        half = 8'h18;
        rd_open(8'h00);
        rd_get(1'b1, BLOCK_COUNT);
        for (int i = 0; i < NUM_BYTES; i++)
            rd_get(i < NUM_BYTES - 1, mdl[i]);
        u_host.stop();
        outs_check();
        half = 8'h0A;
        u_host.start();
        u_host.send(8'hD4, a);
        chk("foreign_ack", 0, 16'(a));
        u_host.stop();
        u_host.start();
        wr(8'hD2);
        wr(8'h83);
        for (int i = 0; i < 4; i++)
            u_host.bit_cell(1'b0, a);
        u_host.stop();
        rd_open(8'h83);
        rd_get(1'b0, mdl[3]);
        u_host.stop();
        // An index past the byte file reads back as zero
        rd_open(8'h8A);
        rd_get(1'b0, 8'h00);
        u_host.stop();
        end_sim();
    end
endmodule : clock_synth_smbus_slave_tb_top
